//--- core/msr_pkg.sv
package msr_pkg;
  localparam int IDX_W = 7;
  localparam int TRIM_W = 15;
  localparam int AXES = 3;

  // register indices; byte address is four times the index
  localparam logic [6:0] OFS_FACT_X = 7'h00;
  localparam logic [6:0] OFS_FACT_Y = 7'h01;
  localparam logic [6:0] OFS_FACT_Z = 7'h02;
  localparam logic [6:0] OFS_DELAY = 7'h67;
  localparam logic [6:0] OFS_PATH_RST = 7'h68;
  localparam logic [6:0] OFS_MOTION = 7'h69;
  localparam logic [6:0] OFS_USER = 7'h6a;
  localparam logic [6:0] OFS_PWR1 = 7'h6b;
  localparam logic [6:0] OFS_PWR2 = 7'h6c;
  localparam logic [6:0] OFS_CNT_HI = 7'h72;
  localparam logic [6:0] OFS_CNT_LO = 7'h73;
  localparam logic [6:0] OFS_QDATA = 7'h74;
  localparam logic [6:0] OFS_IDENT = 7'h75;
  localparam logic [6:0] OFS_MAP_SEL = 7'h7f;

  // per-axis trim pairs, element 0 is x
  localparam logic [2:0][6:0] NAT_TRIM_HI = {7'h7d, 7'h7a, 7'h77};
  localparam logic [2:0][6:0] NAT_TRIM_LO = {7'h7e, 7'h7b, 7'h78};
  localparam logic [2:0][6:0] CMP_TRIM_HI = {7'h0a, 7'h08, 7'h06};
  localparam logic [2:0][6:0] CMP_TRIM_LO = {7'h0b, 7'h09, 7'h07};

  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PWR1 = 8'h01;

  // writable bits; the rest read as zero, except power two bits 7:6 in the compatibility map (wake rate)
  localparam logic [7:0] MASK_DELAY = 8'h9f;
  localparam logic [7:0] MASK_MOTION = 8'hc0;
  localparam logic [7:0] MASK_PWR1 = 8'h7f;
  localparam logic [7:0] MASK_PWR2 = 8'h3f;
  localparam logic [7:0] MASK_CNT_HI = 8'h1f;

  localparam int PWR1_RESET_BIT = 7;
  localparam int PWR1_SLEEP_BIT = 6;
  localparam int WAKE_MSB = 7;
  localparam int WAKE_LSB = 6;
  localparam int MAP_SEL_BIT = 0;
endpackage : msr_pkg

//--- core/msr_acc_if.sv
`timescale 1ns/1ps
interface msr_acc_if;
  logic [6:0] idx;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  modport slave (output idx, output wdata, output wr, input rdata);
  modport core (input idx, input wdata, input wr, output rdata);
endinterface : msr_acc_if

//--- core/msr_bus_slave.sv
`timescale 1ns/1ps
module msr_bus_slave #(
  parameter int ADDR_W = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  msr_acc_if.slave acc
);
  if (ADDR_W != msr_pkg::IDX_W + 2) begin : g_bad_addr
    $error("address width must cover the word index plus two byte bits");
  end

  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic aligned;

  assign aligned = (address[1:0] == 2'h0);
  assign acc.idx = address[ADDR_W-1:2];
  assign acc.wdata = writedata[7:0];
  // a write lands only on the edge where waitrequest is seen low
  assign acc.wr = write && !waitrequest_r && byteenable[0] && aligned;

  // every access is held one cycle, then answered for exactly one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest_r <= 1'b1;
    end else if ((read || write) && waitrequest_r) begin
      waitrequest_r <= 1'b0;
    end else begin
      waitrequest_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_r <= 32'h0;
    end else if (read && waitrequest_r) begin
      readdata_r <= aligned ? {24'h0, acc.rdata} : 32'h0;
    end
  end

  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;

  property p_one_wait;
    @(posedge clk) disable iff (rst)
    (read || write) && waitrequest_r |=> !waitrequest_r ##1 waitrequest_r;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer not after one wait cycle");
endmodule : msr_bus_slave

//--- core/msr_trim_axis.sv
`timescale 1ns/1ps
module msr_trim_axis #(
  parameter int TRIM_W = 15
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [7:0] wdata,
  output logic [TRIM_W-1:0] trim,
  output logic [7:0] high_byte,
  output logic [7:0] low_byte
);
  if (TRIM_W < 9 || TRIM_W > 16) begin : g_bad_w
    $error("trim width must lie between 9 and 16");
  end

  logic [TRIM_W-1:0] trim_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trim_r <= '0;
    end else if (clear) begin
      trim_r <= '0;
    end else begin
      if (wr_high) begin
        trim_r[TRIM_W-1 -: 8] <= wdata;
      end
      if (wr_low) begin
        trim_r[TRIM_W-9:0] <= wdata[7 -: (TRIM_W-8)];
      end
    end
  end

  assign trim = trim_r;
  assign high_byte = trim_r[TRIM_W-1 -: 8];
  // low part is left justified, unused low bits read zero
  assign low_byte = 8'({trim_r[TRIM_W-9:0], {(16-TRIM_W){1'b0}}});
endmodule : msr_trim_axis

//--- core/msr_regs.sv
// Functional notes
// - every register resets to zero except power one, identity and factory test
// - power control one at index 107 resets to 0x01
// - factory test registers 0 to 2 hold nonzero values; device reset keeps them
// - factory test registers read back the 8-bit manufacturing test result
// - high register of a pair holds upper 8 bits, low the rest
// - after power-up the device is active, not asleep
// - native map by default; compatibility map differs only at listed registers
// - compatibility mode moves accel trim pairs to indices 6 to 11
// - compatibility mode power two bits 7:6 are wake rate; 5:0 axis disables
`timescale 1ns/1ps
module msr_regs #(
  parameter logic [7:0] IDENTITY = 8'h5a, // arbitrary identity value
  parameter logic [7:0] FACT_X = 8'h11,
  parameter logic [7:0] FACT_Y = 8'h22,
  parameter logic [7:0] FACT_Z = 8'h33,
  parameter int TRIM_W = msr_pkg::TRIM_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic compat_mode,
  output logic sleep,
  output logic [2:0] clock_source,
  output logic [5:0] axis_disable,
  output logic [1:0] low_power_wake_rate,
  output logic [2:0] path_reset_pulse,
  output logic [TRIM_W-1:0] accel_x_trim,
  output logic [TRIM_W-1:0] accel_y_trim,
  output logic [TRIM_W-1:0] accel_z_trim
);
  // factory values must stay nonzero through any reset
  if (FACT_X == 8'h00 || FACT_Y == 8'h00 || FACT_Z == 8'h00) begin : g_bad_fact
    $error("factory test values must be nonzero");
  end

  msr_acc_if acc ();

  msr_bus_slave #(
    .ADDR_W(9)
  ) u_bus (
    .clk(clk),
    .rst(rst),
    .address(avs_address),
    .read(avs_read),
    .write(avs_write),
    .writedata(avs_writedata),
    .byteenable(avs_byteenable),
    .readdata(avs_readdata),
    .waitrequest(avs_waitrequest),
    .acc(acc.slave)
  );

  logic [7:0] delay_r;
  logic [7:0] motion_r;
  logic [7:0] user_r;
  logic [7:0] pwr1_r;
  logic [7:0] pwr2_r;
  logic [7:0] cnt_hi_r;
  logic [7:0] cnt_lo_r;
  logic [7:0] qdata_r;
  logic [1:0] wake_r;
  logic compat_r;
  logic soft_rst_r;
  logic [2:0] path_pulse_r;
  logic [2:0][7:0] fact_r;
  logic [2:0][6:0] hi_ofs;
  logic [2:0][6:0] lo_ofs;
  logic [2:0][7:0] hi_b;
  logic [2:0][7:0] lo_b;
  logic [2:0][TRIM_W-1:0] trim;
  logic [7:0] rd_mux;

  function automatic logic hit(input logic [6:0] ofs);
    return acc.wr && (acc.idx == ofs);
  endfunction : hit

  // device reset bit: one-cycle pulse that reloads all defaults except the factory results
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= hit(msr_pkg::OFS_PWR1) && acc.wdata[msr_pkg::PWR1_RESET_BIT];
    end
  end

  // general control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delay_r <= msr_pkg::RST_ZERO;
      motion_r <= msr_pkg::RST_ZERO;
      user_r <= msr_pkg::RST_ZERO;
      pwr2_r <= msr_pkg::RST_ZERO;
      cnt_hi_r <= msr_pkg::RST_ZERO;
      cnt_lo_r <= msr_pkg::RST_ZERO;
      qdata_r <= msr_pkg::RST_ZERO;
    end else if (soft_rst_r) begin
      delay_r <= msr_pkg::RST_ZERO;
      motion_r <= msr_pkg::RST_ZERO;
      user_r <= msr_pkg::RST_ZERO;
      pwr2_r <= msr_pkg::RST_ZERO;
      cnt_hi_r <= msr_pkg::RST_ZERO;
      cnt_lo_r <= msr_pkg::RST_ZERO;
      qdata_r <= msr_pkg::RST_ZERO;
    end else begin
      if (hit(msr_pkg::OFS_DELAY)) begin
        delay_r <= acc.wdata & msr_pkg::MASK_DELAY;
      end
      if (hit(msr_pkg::OFS_MOTION)) begin
        motion_r <= acc.wdata & msr_pkg::MASK_MOTION;
      end
      if (hit(msr_pkg::OFS_USER)) begin
        user_r <= acc.wdata;
      end
      if (hit(msr_pkg::OFS_PWR2)) begin
        pwr2_r <= acc.wdata & msr_pkg::MASK_PWR2;
      end
      if (hit(msr_pkg::OFS_CNT_HI)) begin
        cnt_hi_r <= acc.wdata & msr_pkg::MASK_CNT_HI;
      end
      if (hit(msr_pkg::OFS_CNT_LO)) begin
        cnt_lo_r <= acc.wdata;
      end
      if (hit(msr_pkg::OFS_QDATA)) begin
        qdata_r <= acc.wdata;
      end
    end
  end

  // power control one: wakes active, clock select 1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr1_r <= msr_pkg::RST_PWR1;
    end else if (soft_rst_r) begin
      pwr1_r <= msr_pkg::RST_PWR1;
    end else if (hit(msr_pkg::OFS_PWR1)) begin
      // reset bit is self-clearing, never stored
      pwr1_r <= acc.wdata & msr_pkg::MASK_PWR1;
    end
  end

  // wake rate only exists in the compatibility map
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_r <= 2'h0;
    end else if (soft_rst_r) begin
      wake_r <= 2'h0;
    end else if (hit(msr_pkg::OFS_PWR2) && compat_r) begin
      wake_r <= acc.wdata[msr_pkg::WAKE_MSB:msr_pkg::WAKE_LSB];
    end
  end

  // map select; native after any reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      compat_r <= 1'b0;
    end else if (soft_rst_r) begin
      compat_r <= 1'b0;
    end else if (hit(msr_pkg::OFS_MAP_SEL)) begin
      compat_r <= acc.wdata[msr_pkg::MAP_SEL_BIT];
    end
  end

  // path reset bits act as one-cycle strobes and read back zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      path_pulse_r <= 3'h0;
    end else if (hit(msr_pkg::OFS_PATH_RST)) begin
      path_pulse_r <= acc.wdata[2:0];
    end else begin
      path_pulse_r <= 3'h0;
    end
  end

  // factory results: loaded at power-on, untouched by device reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fact_r <= {FACT_Z, FACT_Y, FACT_X};
    end else begin
      for (int i = 0; i < msr_pkg::AXES; i++) begin
        if (hit(msr_pkg::OFS_FACT_X + 7'(i))) begin
          fact_r[i] <= acc.wdata;
        end
      end
    end
  end

  // trim pair location follows the active map
  always_comb begin
    hi_ofs = compat_r ? msr_pkg::CMP_TRIM_HI : msr_pkg::NAT_TRIM_HI;
    lo_ofs = compat_r ? msr_pkg::CMP_TRIM_LO : msr_pkg::NAT_TRIM_LO;
  end

  for (genvar a = 0; a < msr_pkg::AXES; a++) begin : g_axis
    msr_trim_axis #(
      .TRIM_W(TRIM_W)
    ) u_trim (
      .clk(clk),
      .rst(rst),
      .clear(soft_rst_r),
      // written out, not through hit(): a port expression would not see acc.wr change
      .wr_high(acc.wr && (acc.idx == hi_ofs[a])),
      .wr_low(acc.wr && (acc.idx == lo_ofs[a])),
      .wdata(acc.wdata),
      .trim(trim[a]),
      .high_byte(hi_b[a]),
      .low_byte(lo_b[a])
    );
  end

  // read mux; unmapped indices read zero
  always_comb begin
    rd_mux = 8'h00;
    case (acc.idx)
      msr_pkg::OFS_FACT_X: rd_mux = fact_r[0];
      msr_pkg::OFS_FACT_Y: rd_mux = fact_r[1];
      msr_pkg::OFS_FACT_Z: rd_mux = fact_r[2];
      msr_pkg::OFS_DELAY: rd_mux = delay_r;
      msr_pkg::OFS_PATH_RST: rd_mux = 8'h00;
      msr_pkg::OFS_MOTION: rd_mux = motion_r;
      msr_pkg::OFS_USER: rd_mux = user_r;
      msr_pkg::OFS_PWR1: rd_mux = pwr1_r;
      msr_pkg::OFS_PWR2: rd_mux = compat_r ? {wake_r, pwr2_r[5:0]} : pwr2_r;
      msr_pkg::OFS_CNT_HI: rd_mux = cnt_hi_r;
      msr_pkg::OFS_CNT_LO: rd_mux = cnt_lo_r;
      msr_pkg::OFS_QDATA: rd_mux = qdata_r;
      msr_pkg::OFS_IDENT: rd_mux = IDENTITY;
      msr_pkg::OFS_MAP_SEL: rd_mux = {7'h00, compat_r};
      default: rd_mux = 8'h00;
    endcase
    for (int a = 0; a < msr_pkg::AXES; a++) begin
      if (acc.idx == hi_ofs[a]) begin
        rd_mux = hi_b[a];
      end
      if (acc.idx == lo_ofs[a]) begin
        rd_mux = lo_b[a];
      end
    end
  end

  assign acc.rdata = rd_mux;

  assign compat_mode = compat_r;
  assign sleep = pwr1_r[msr_pkg::PWR1_SLEEP_BIT];
  assign clock_source = pwr1_r[2:0];
  assign axis_disable = pwr2_r[5:0];
  assign low_power_wake_rate = wake_r;
  assign path_reset_pulse = path_pulse_r;
  assign accel_x_trim = trim[0];
  assign accel_y_trim = trim[1];
  assign accel_z_trim = trim[2];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_released;
    $past(rst);
  endsequence

  sequence s_cmp_x_hi_wr;
    acc.wr && compat_r && !soft_rst_r && acc.idx == msr_pkg::CMP_TRIM_HI[0];
  endsequence

  sequence s_soft_reset;
    hit(msr_pkg::OFS_PWR1) && acc.wdata[msr_pkg::PWR1_RESET_BIT] ##1 soft_rst_r;
  endsequence

  property p_soft_defaults;
    s_soft_reset |=> delay_r == 8'h00 && user_r == 8'h00 && motion_r == 8'h00
      && !compat_r && accel_x_trim == '0;
  endproperty
  a_soft_defaults: assert property (p_soft_defaults) else $error("device reset left a nonzero register");

  property p_pwr1_reset;
    s_released |-> pwr1_r == 8'h01;
  endproperty
  a_pwr1_reset: assert property (p_pwr1_reset) else $error("power control one not 0x01 after reset");

  property p_fact_kept;
    s_soft_reset |=> fact_r == $past(fact_r, 2) && fact_r[0] != 8'h00;
  endproperty
  a_fact_kept: assert property (p_fact_kept) else $error("factory value lost on device reset");

  property p_fact_read;
    acc.idx == msr_pkg::OFS_FACT_Y |-> acc.rdata == fact_r[1];
  endproperty
  a_fact_read: assert property (p_fact_read) else $error("factory value read back wrong");

  property p_high_upper;
    !compat_r && acc.idx == msr_pkg::NAT_TRIM_HI[1] |-> acc.rdata == accel_y_trim[14:7];
  endproperty
  a_high_upper: assert property (p_high_upper) else $error("high trim byte not the upper bits");

  property p_active;
    s_released |-> !sleep ##1 !sleep;
  endproperty
  a_active: assert property (p_active) else $error("device asleep after reset");

  property p_native_default;
    s_released |-> !compat_mode && low_power_wake_rate == 2'h0;
  endproperty
  a_native_default: assert property (p_native_default) else $error("map not native after reset");

  property p_compat_move;
    s_cmp_x_hi_wr |=> accel_x_trim[14:7] == $past(acc.wdata);
  endproperty
  a_compat_move: assert property (p_compat_move) else $error("compat trim write missed");

  property p_native_hidden;
    compat_r && acc.idx == msr_pkg::NAT_TRIM_HI[0] |-> acc.rdata == 8'h00;
  endproperty
  a_native_hidden: assert property (p_native_hidden) else $error("native trim visible in compat map");

  property p_wake_native;
    hit(msr_pkg::OFS_PWR2) && !compat_r |=> $stable(wake_r) && axis_disable == $past(acc.wdata[5:0]);
  endproperty
  a_wake_native: assert property (p_wake_native) else $error("wake field written in native map");

  property p_low_reserved;
    acc.idx == lo_ofs[2] |-> acc.rdata[0] == 1'b0 && acc.rdata[7:1] == accel_z_trim[6:0];
  endproperty
  a_low_reserved: assert property (p_low_reserved) else $error("low trim byte layout wrong");

  property p_wake_compat;
    hit(msr_pkg::OFS_PWR2) && compat_r && !soft_rst_r |=> low_power_wake_rate == $past(acc.wdata[7:6]);
  endproperty
  a_wake_compat: assert property (p_wake_compat) else $error("wake field not written in compat map");

  property p_pwr1_reload;
    s_soft_reset |=> pwr1_r == 8'h01 && !sleep;
  endproperty
  a_pwr1_reload: assert property (p_pwr1_reload) else $error("device reset did not reload power one");

  property p_map_select;
    hit(msr_pkg::OFS_MAP_SEL) && !soft_rst_r |=> compat_mode == $past(acc.wdata[msr_pkg::MAP_SEL_BIT]);
  endproperty
  a_map_select: assert property (p_map_select) else $error("map select write missed");
endmodule : msr_regs

//--- dv/msr_regs_test.sv
`timescale 1ns/1ps
module msr_regs_test;
  localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary identity value
  localparam logic [7:0] FX = 8'h4b;
  localparam logic [7:0] FY = 8'h96;
  localparam logic [7:0] FZ = 8'he1;
  logic clk;
  logic rst;
  logic [8:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic compat_mode;
  logic sleep;
  logic [2:0] clock_source;
  logic [5:0] axis_disable;
  logic [1:0] low_power_wake_rate;
  logic [2:0] path_reset_pulse;
  logic [msr_pkg::TRIM_W-1:0] accel_x_trim;
  logic [msr_pkg::TRIM_W-1:0] accel_y_trim;
  logic [msr_pkg::TRIM_W-1:0] accel_z_trim;
  logic [7:0] m [0:127];
  logic [31:0] q;
  logic [2:0] seen;
  int hits;
  int errors;
  int checks_done;

  msr_regs #(.IDENTITY(ID_VAL), .FACT_X(FX), .FACT_Y(FY), .FACT_Z(FZ), .TRIM_W(msr_pkg::TRIM_W)) dut (
    .clk(clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .compat_mode(compat_mode),
    .sleep(sleep),
    .clock_source(clock_source),
    .axis_disable(axis_disable),
    .low_power_wake_rate(low_power_wake_rate),
    .path_reset_pulse(path_reset_pulse),
    .accel_x_trim(accel_x_trim),
    .accel_y_trim(accel_y_trim),
    .accel_z_trim(accel_z_trim)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic summarize();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, s);
    end
  endtask : chk

  // writable bits as seen through the map currently selected
  function automatic logic [7:0] wmask(input logic [6:0] i);
    logic c;
    c = m[127][0];
    case (i)
      7'h00, 7'h01, 7'h02, 7'h6a, 7'h73, 7'h74: return 8'hff;
      7'h67: return 8'h9f;
      7'h69: return 8'hc0;
      7'h6b: return 8'h7f;
      7'h6c: return c ? 8'hff : 8'h3f;
      7'h72: return 8'h1f;
      7'h7f: return 8'h01;
      7'h77, 7'h7a, 7'h7d: return c ? 8'h00 : 8'hff;
      7'h78, 7'h7b, 7'h7e: return c ? 8'h00 : 8'hfe;
      7'h06, 7'h08, 7'h0a: return c ? 8'hff : 8'h00;
      7'h07, 7'h09, 7'h0b: return c ? 8'hfe : 8'h00;
      default: return 8'h00;
    endcase
  endfunction : wmask

  // both maps share one trim store, kept at the native indices
  function automatic int phys(input logic [6:0] i);
    if (i >= 7'h06 && i <= 7'h0b) begin
      return 119 + 3 * ((int'(i) - 6) / 2) + (int'(i) - 6) % 2;
    end
    return int'(i);
  endfunction : phys

  function automatic logic [7:0] exp_rd(input logic [6:0] i);
    if (i == 7'h75) begin
      return ID_VAL;
    end
    return m[phys(i)] & wmask(i);
  endfunction : exp_rd

  task automatic mdl_rst(input bit full);
    for (int k = 0; k < 128; k++) begin
      if (k > 2 || full) begin
        m[k] = 8'h00;
      end
    end
    if (full) begin
      m[0] = FX;
      m[1] = FY;
      m[2] = FZ;
    end
    m[107] = 8'h01;
  endtask : mdl_rst

  task automatic acc(input logic rd, input logic [8:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'($urandom), d};
    avs_byteenable <= be;
    avs_read <= rd;
    avs_write <= !rd;
    // waitrequest and readdata are taken at the rising edge, before that edge updates them
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        errors++;
        summarize();
      end
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("wait_cycles", 32'(n), 32'd2);
  endtask : acc

  task automatic chk_out();
    repeat (2) @(negedge clk);
    chk("compat_mode", compat_mode, m[127][0]);
    chk("sleep", sleep, m[107][6]);
    chk("clock_source", clock_source, m[107][2:0]);
    chk("axis_disable", axis_disable, m[108][5:0]);
    chk("wake_rate", low_power_wake_rate, m[108][7:6]);
    chk("x_trim", accel_x_trim, {m[119], m[120][7:1]});
    chk("y_trim", accel_y_trim, {m[122], m[123][7:1]});
    chk("z_trim", accel_z_trim, {m[125], m[126][7:1]});
  endtask : chk_out

  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    acc(1'b0, {i, 2'b00}, d, {3'($urandom), 1'b1});
    m[phys(i)] = (m[phys(i)] & ~wmask(i)) | (d & wmask(i));
    if (i == 7'h6b && d[7]) mdl_rst(1'b0);
    chk_out();
  endtask : wr

  task automatic sweep();
    for (int i = 0; i < 128; i++) begin
      acc(1'b1, {7'(i), 2'b00}, 8'h00, 4'hf);
      chk("readdata", q, {24'h0, exp_rd(7'(i))});
    end
  endtask : sweep

  task automatic rnd_wr(input int lo, input int hi);
    logic [7:0] d;
    for (int i = lo; i <= hi; i++) begin
      d = 8'($urandom);
      // factory results stay nonzero even when rewritten
      if (i <= 2 && d == 8'h00) d = 8'h01;
      if (i == 107) d[7] = 1'b0;
      if (i != 127) wr(7'(i), d);
    end
  endtask : rnd_wr

  initial begin
    rst = 1'b1;
    avs_address = 9'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    errors = 0;
    checks_done = 0;
    void'($urandom(69194));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    mdl_rst(1'b1);
    chk_out();
    sweep();
    // native map, every index except map select (127) written with random data
    rnd_wr(0, 127);
    sweep();
    // misaligned and byte-disabled accesses are answered but change nothing
    acc(1'b0, {7'h6a, 2'b10}, 8'h5d, 4'hf);
    acc(1'b0, {7'h74, 2'b00}, 8'ha6, 4'he);
    acc(1'b1, {7'h6a, 2'b01}, 8'h00, 4'hf);
    chk("misaligned_read", q, 32'h0);
    sweep();
    // compatibility map: trims move, wake field appears
    wr(7'h7f, 8'h01);
    rnd_wr(0, 11);
    rnd_wr(108, 108);
    rnd_wr(119, 126);
    sweep();
    wr(7'h7f, 8'h00);
    sweep();
    for (int v = 1; v < 8; v++) begin
      acc(1'b0, {7'h68, 2'b00}, 8'(v), 4'h1);
      seen = 3'h0;
      hits = 0;
      repeat (3) begin
        @(negedge clk);
        seen = seen | path_reset_pulse;
        if (path_reset_pulse !== 3'h0) hits++;
      end
      chk("path_reset_pulse", seen, 32'(v));
      chk("pulse_cycles", 32'(hits), 32'd1);
    end
    // device reset from compatibility mode keeps factory values
    wr(7'h7f, 8'h01);
    rnd_wr(6, 11);
    wr(7'h6b, 8'h80 | 8'($urandom));
    sweep();
    // hard reset in mid-run restores factory results
    rnd_wr(0, 2);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    mdl_rst(1'b1);
    chk_out();
    sweep();
    summarize();
  end
endmodule : msr_regs_test
